// ==== hdl/mbs_defs.vh ====
// constants for the ascii status-register responder
`ifndef MBS_DEFS_VH
`define MBS_DEFS_VH
// framing characters
`define MBS_CHAR_COLON 8'h3A
`define MBS_CHAR_CR 8'h0D
`define MBS_CHAR_LF 8'h0A
// protocol field values
`define MBS_FUNC_READ 8'h03
`define MBS_BYTE_COUNT 8'h02
`define MBS_REG_COUNT 16'h0001
`define MBS_ADDR_MIN 8'h01
`define MBS_ADDR_MAX 8'h10
// register offsets
`define MBS_REG_POS 16'h9014
`define MBS_REG_EXP 16'h9015
// field positions
`define MBS_POS_LSB 0
`define MBS_POS_MSB 9
`define MBS_EXP_FLAG8 8
`define MBS_EXP_FLAG11 11
// frame sizes
`define MBS_QUERY_BYTES 4'h7
`define MBS_RESP_CHARS 4'hF
`define MBS_RESP_LAST 4'hE
`endif

// ==== hdl/mbs_lrc.v ====
// eight-bit longitudinal check accumulator
`timescale 1ns/100ps
`default_nettype none
module mbs_lrc
(
  input wire clk_in,
  input wire arst_n_in,
  input wire clear_in,
  input wire add_in,
  input wire [7:0] byte_in,
  output reg [7:0] sum_out
);
  // carries are dropped, sum stays eight bits
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sum_out <= 8'h00;
    else if (clear_in)
      sum_out <= 8'h00;
    else if (add_in)
      sum_out <= sum_out + byte_in;
  end
endmodule
`default_nettype wire

// ==== hdl/mbs_tx.v ====
// response frame serializer: fifteen ascii characters
`timescale 1ns/100ps
`default_nettype none
`include "mbs_defs.vh"
module mbs_tx
(
  input wire clk_in,
  input wire arst_n_in,
  input wire start_in,
  input wire [7:0] addr_in,
  input wire [15:0] data_in,
  input wire ready_in,
  output reg [7:0] char_out,
  output reg valid_out,
  output reg done_out
);
  reg [3:0] idx;
  reg [7:0] addr;
  reg [15:0] data;
  reg [7:0] lrc;
  reg [7:0] next_char;
  wire [3:0] nxt_idx;
  localparam [7:0] FUNC_CODE = `MBS_FUNC_READ;
  localparam [7:0] BYTE_CODE = `MBS_BYTE_COUNT;

  function [7:0] nib2hex;
    input [3:0] n;
    begin
      nib2hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    end
  endfunction

  assign nxt_idx = idx + 4'h1;

  // character for the slot after the current one
  always @*
  begin
    case (nxt_idx)
      4'h1: next_char = nib2hex(addr[7:4]);
      4'h2: next_char = nib2hex(addr[3:0]);
      4'h3: next_char = nib2hex(FUNC_CODE[7:4]);
      4'h4: next_char = nib2hex(FUNC_CODE[3:0]);
      4'h5: next_char = nib2hex(BYTE_CODE[7:4]);
      4'h6: next_char = nib2hex(BYTE_CODE[3:0]);
      4'h7: next_char = nib2hex(data[15:12]);
      4'h8: next_char = nib2hex(data[11:8]);
      4'h9: next_char = nib2hex(data[7:4]);
      4'hA: next_char = nib2hex(data[3:0]);
      4'hB: next_char = nib2hex(lrc[7:4]);
      4'hC: next_char = nib2hex(lrc[3:0]);
      4'hD: next_char = `MBS_CHAR_CR;
      4'hE: next_char = `MBS_CHAR_LF;
      default: next_char = `MBS_CHAR_COLON;
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      idx <= 4'h0;
      addr <= 8'h00;
      data <= 16'h0000;
      lrc <= 8'h00;
      char_out <= 8'h00;
      valid_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in && !valid_out)
      begin
        idx <= 4'h0;
        addr <= addr_in;
        data <= data_in;
        lrc <= 8'h00 - (addr_in + `MBS_FUNC_READ + `MBS_BYTE_COUNT + data_in[15:8]
          + data_in[7:0]);
        char_out <= `MBS_CHAR_COLON;
        valid_out <= 1'b1;
      end
      else if (valid_out && ready_in)
      begin
        if (idx == `MBS_RESP_LAST)
        begin
          valid_out <= 1'b0;
          done_out <= 1'b1;
        end
        else
        begin
          idx <= nxt_idx;
          char_out <= next_char;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/mbs_reader.v ====
// ascii register-read responder for two status words
`timescale 1ns/100ps
`default_nettype none
`include "mbs_defs.vh"
module mbs_reader
(
  input wire CLK_IN,
  input wire ARST_N_IN,
  input wire [7:0] RX_CHAR_IN,
  input wire RX_VALID_IN,
  output wire [7:0] TX_CHAR_OUT,
  output wire TX_VALID_OUT,
  input wire TX_READY_IN,
  input wire [3:0] AXIS_NUMBER_IN,
  input wire [9:0] POSITION_COMPLETE_NUMBER_IN,
  input wire EXPANSION_FLAG_BIT8_IN,
  input wire EXPANSION_FLAG_BIT11_IN,
  output wire BUSY_OUT,
  output reg FRAME_DROP_OUT
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_HI = 3'h1;
  localparam [2:0] ST_LO = 3'h2;
  localparam [2:0] ST_LF = 3'h3;
  localparam [2:0] ST_SEND = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [55:0] frame;
  reg [3:0] nbytes;
  reg [3:0] hinib;
  reg tx_start;
  reg [7:0] tx_addr;
  reg [15:0] tx_data;
  reg next_drop;
  reg next_start;
  reg lrc_clear;
  reg lrc_add;

  wire [7:0] lrc_sum;
  wire tx_done;
  wire rx_is_hex;
  wire [3:0] rx_nib;
  wire [7:0] rx_byte;
  wire [7:0] own_addr;
  wire [7:0] q_addr;
  wire [7:0] q_func;
  wire [15:0] q_start;
  wire [15:0] q_count;
  wire hit_pos;
  wire hit_exp;
  wire frame_ok;
  wire [15:0] pos_word;
  wire [15:0] exp_word;

  // accepts upper and lower case hex digits
  function is_hex;
    input [7:0] c;
    begin
      is_hex = ((c >= 8'h30) && (c <= 8'h39)) || ((c >= 8'h41) && (c <= 8'h46))
        || ((c >= 8'h61) && (c <= 8'h66));
    end
  endfunction

  function [3:0] hex2nib;
    input [7:0] c;
    begin
      if (c <= 8'h39)
        hex2nib = c[3:0];
      else
        hex2nib = c[3:0] + 4'h9;
    end
  endfunction

  assign rx_is_hex = is_hex(RX_CHAR_IN);
  assign rx_nib = hex2nib(RX_CHAR_IN);
  assign rx_byte = {hinib, rx_nib};

  // axis 0..15 maps onto addresses 01..10 hex
  assign own_addr = {4'h0, AXIS_NUMBER_IN} + `MBS_ADDR_MIN;

  // query bytes in arrival order: address, function, start, count, check
  assign q_addr = frame[55:48];
  assign q_func = frame[47:40];
  assign q_start = frame[39:24];
  assign q_count = frame[23:8];

  assign hit_pos = (q_start == `MBS_REG_POS) && (q_count == `MBS_REG_COUNT);
  assign hit_exp = (q_start == `MBS_REG_EXP) && (q_count == `MBS_REG_COUNT);

  // check byte included, so a good frame sums to zero
  assign frame_ok = (nbytes == `MBS_QUERY_BYTES) && (lrc_sum == 8'h00)
    && (q_addr == own_addr) && (own_addr <= `MBS_ADDR_MAX)
    && (q_func == `MBS_FUNC_READ) && (hit_pos || hit_exp);

  // status words, unused bits tied low
  assign pos_word = {6'h00, POSITION_COMPLETE_NUMBER_IN[`MBS_POS_MSB-`MBS_POS_LSB:0]};
  assign exp_word = {4'h0, EXPANSION_FLAG_BIT11_IN, 2'h0, EXPANSION_FLAG_BIT8_IN,
    8'h00};

  assign BUSY_OUT = (state == ST_SEND);

  mbs_lrc u_lrc
  (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .clear_in(lrc_clear),
    .add_in(lrc_add),
    .byte_in(rx_byte),
    .sum_out(lrc_sum)
  );

  mbs_tx u_tx
  (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .start_in(tx_start),
    .addr_in(tx_addr),
    .data_in(tx_data),
    .ready_in(TX_READY_IN),
    .char_out(TX_CHAR_OUT),
    .valid_out(TX_VALID_OUT),
    .done_out(tx_done)
  );

  // receive sequencing; characters arriving while answering are ignored
  always @*
  begin
    next_state = state;
    next_drop = 1'b0;
    next_start = 1'b0;
    lrc_clear = 1'b0;
    lrc_add = 1'b0;
    if (state == ST_SEND)
    begin
      if (tx_done)
        next_state = ST_IDLE;
    end
    else if (RX_VALID_IN)
    begin
      if (RX_CHAR_IN == `MBS_CHAR_COLON)
      begin
        next_state = ST_HI;
        lrc_clear = 1'b1;
        if (state != ST_IDLE)
          next_drop = 1'b1;
      end
      else
      begin
        case (state)
          ST_HI:
          begin
            if (rx_is_hex)
              next_state = ST_LO;
            else if (RX_CHAR_IN == `MBS_CHAR_CR)
              next_state = ST_LF;
            else
            begin
              next_state = ST_IDLE;
              next_drop = 1'b1;
            end
          end
          ST_LO:
          begin
            if (rx_is_hex)
            begin
              next_state = ST_HI;
              lrc_add = 1'b1;
            end
            else
            begin
              next_state = ST_IDLE;
              next_drop = 1'b1;
            end
          end
          ST_LF:
          begin
            if ((RX_CHAR_IN == `MBS_CHAR_LF) && frame_ok)
            begin
              next_state = ST_SEND;
              next_start = 1'b1;
            end
            else
            begin
              next_state = ST_IDLE;
              next_drop = 1'b1;
            end
          end
          default:
            next_state = ST_IDLE;
        endcase
      end
    end
  end

  always @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      state <= ST_IDLE;
      frame <= 56'h0;
      nbytes <= 4'h0;
      hinib <= 4'h0;
      tx_start <= 1'b0;
      tx_addr <= 8'h00;
      tx_data <= 16'h0000;
      FRAME_DROP_OUT <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tx_start <= next_start;
      FRAME_DROP_OUT <= next_drop;
      if (lrc_clear)
        nbytes <= 4'h0;
      if (RX_VALID_IN && (state == ST_HI) && rx_is_hex)
        hinib <= rx_nib;
      if (lrc_add)
      begin
        frame <= {frame[47:0], rx_byte};
        // saturate so overlong queries stay rejected
        if (nbytes != 4'hF)
          nbytes <= nbytes + 4'h1;
      end
      if (next_start)
      begin
        tx_addr <= own_addr;
        tx_data <= hit_pos ? pos_word : exp_word;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/mbs_host.sv ====
// host-side model: sends queries, takes response characters
`timescale 1ns/100ps
`default_nettype none
module mbs_host
(
  input wire logic clk_in,
  input wire logic [7:0] char_in,
  input wire logic valid_in,
  input wire logic slow_in,
  output logic [7:0] char_out,
  output logic valid_out,
  output wire logic ready_out
);
  logic [7:0] got [$];
  logic [1:0] tick = 2'h0;
  // slow mode takes one character in four
  assign ready_out = !slow_in || tick == 2'h3;
  initial
  begin
    char_out = 8'h00;
    valid_out = 1'b0;
  end
  always @(posedge clk_in)
  begin
    tick <= tick + 2'h1;
    if (valid_in && ready_out)
      got.push_back(char_in);
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return n < 4'hA ? 8'h30 + n : 8'h37 + n;
  endfunction
  task automatic put(input logic [7:0] c);
    @(posedge clk_in);
    #1;
    char_out = c;
    valid_out = 1'b1;
  endtask
  // a nonzero x spoils the check value
  task automatic send(input logic [7:0] a, input logic [15:0] r, input logic [7:0] x);
    logic [7:0] b [0:6];
    b = '{a, 8'h03, r[15:8], r[7:0], 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 6; i++)
      b[6] = b[6] - b[i];
    b[6] = b[6] ^ x;
    put(8'h3A);
    foreach (b[i])
    begin
      put(hx(b[i][7:4]));
      put(hx(b[i][3:0]));
    end
    put(8'h0D);
    put(8'h0A);
    @(posedge clk_in);
    #1;
    valid_out = 1'b0;
    char_out = ~char_out;
  endtask
endmodule
`default_nettype wire

// ==== dv/mbs_reader_sva.sv ====
// port checks of the status responder
`timescale 1ns/100ps
`default_nettype none
module mbs_reader_sva
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic [7:0] TX_CHAR_OUT,
  input wire logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  input wire logic BUSY_OUT,
  input wire logic FRAME_DROP_OUT
);
  logic [3:0] idx;
  wire take = TX_VALID_OUT && TX_READY_IN;
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  // position of the character being taken within the response
  always @(posedge CLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN)
      idx <= 4'h0;
    else if (take)
      idx <= TX_CHAR_OUT == 8'h3A ? 4'h1 : idx + 4'h1;
  char_hold_a: assert property (
    TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_CHAR_OUT)) else $error("char moved");
  head_colon_a: assert property (
    $rose(TX_VALID_OUT) |-> TX_CHAR_OUT == 8'h3A) else $error("no colon");
  busy_cover_a: assert property (
    TX_VALID_OUT |-> BUSY_OUT) else $error("idle while sending");
  func_echo_a: assert property (
    take && idx == 4'h4 |-> TX_CHAR_OUT == 8'h33) else $error("bad function");
  byte_count_a: assert property (
    take && idx == 4'h6 |-> TX_CHAR_OUT == 8'h32) else $error("bad byte count");
  frame_len_a: assert property (
    take && TX_CHAR_OUT == 8'h0A |-> idx == 4'hE) else $error("bad length");
  cr_lf_a: assert property (
    take && TX_CHAR_OUT == 8'h0D |=> TX_VALID_OUT && TX_CHAR_OUT == 8'h0A) else $error("no lf");
  frame_end_a: assert property (
    take && TX_CHAR_OUT == 8'h0A |=> !TX_VALID_OUT ##[1:2] !BUSY_OUT) else $error("no end");
  hex_only_a: assert property (
    take && idx > 4'h0 && idx < 4'hD |-> TX_CHAR_OUT inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("not hex");
  drop_quiet_a: assert property (
    FRAME_DROP_OUT |-> !BUSY_OUT && !TX_VALID_OUT) else $error("answer after drop");
  answer_soon_a: assert property (
    $rose(BUSY_OUT) |-> ##[1:3] TX_VALID_OUT) else $error("late answer");
endmodule
bind mbs_reader mbs_reader_sva sva_u (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN),
  .TX_CHAR_OUT(TX_CHAR_OUT), .TX_VALID_OUT(TX_VALID_OUT), .TX_READY_IN(TX_READY_IN),
  .BUSY_OUT(BUSY_OUT), .FRAME_DROP_OUT(FRAME_DROP_OUT));
`default_nettype wire

// ==== dv/mbs_reader_tb.sv ====
// random testbench of the status responder
`timescale 1ns/100ps
`default_nettype none
module mbs_reader_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] axis = 4'h0;
  logic [9:0] pos = 10'h000;
  logic f8 = 1'b0;
  logic f11 = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rx_char;
  logic rx_valid;
  logic [7:0] tx_char;
  logic tx_valid;
  logic tx_ready;
  logic busy;
  logic drop;
  logic [31:0] seed = 32'hC02FA93A;
  int err_count = 0;
  int check_count = 0;
  int drops = 0;
  int cycles = 0;
  mbs_reader dut_u (.CLK_IN(clk), .ARST_N_IN(arst_n), .RX_CHAR_IN(rx_char),
    .RX_VALID_IN(rx_valid), .TX_CHAR_OUT(tx_char), .TX_VALID_OUT(tx_valid),
    .TX_READY_IN(tx_ready), .AXIS_NUMBER_IN(axis), .POSITION_COMPLETE_NUMBER_IN(pos),
    .EXPANSION_FLAG_BIT8_IN(f8), .EXPANSION_FLAG_BIT11_IN(f11), .BUSY_OUT(busy),
    .FRAME_DROP_OUT(drop));
  mbs_host host_u (.clk_in(clk), .char_in(tx_char), .valid_in(tx_valid), .slow_in(slow),
    .char_out(rx_char), .valid_out(rx_valid), .ready_out(tx_ready));
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic results();
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    drops <= drops + (drop === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      results();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic expect_resp(input logic [7:0] a, input logic [15:0] w);
    logic [7:0] e [$];
    logic [7:0] s;
    int n;
    s = 8'h00 - a - 8'h05 - w[15:8] - w[7:0];
    e = '{8'h3A, host_u.hx(a[7:4]), host_u.hx(a[3:0]), 8'h30, 8'h33, 8'h30, 8'h32,
      host_u.hx(w[15:12]), host_u.hx(w[11:8]), host_u.hx(w[7:4]), host_u.hx(w[3:0]),
      host_u.hx(s[7:4]), host_u.hx(s[3:0]), 8'h0D, 8'h0A};
    n = 0;
    while (host_u.got.size() < 15 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    repeat (6) @(posedge clk);
    chk(8'(host_u.got.size()), 8'h0F);
    foreach (e[i])
      chk(host_u.got[i], e[i]);
    host_u.got.delete();
  endtask
  task automatic expect_drop();
    int d0;
    d0 = drops;
    repeat (40) @(posedge clk);
    chk(8'(drops - d0), 8'h01);
    chk(8'(host_u.got.size()), 8'h00);
    host_u.got.delete();
  endtask
  initial
  begin
    logic [31:0] r;
    logic [7:0] a;
    logic [15:0] w;
    repeat (5) @(posedge clk);
    #1;
    arst_n = 1'b1;
    for (int k = 0; k < 24; k++)
    begin
      @(posedge clk);
      #1;
      r = rnd();
      axis = r[3:0];
      pos = r[13:4];
      {f11, f8} = r[15:14];
      slow = r[16];
      if (k == 0)
        axis = 4'hF;
      if (k == 1)
        {f11, f8} = 2'b01;
      if (k == 2)
        pos = 10'h3FF;
      a = {4'h0, axis} + 8'h01;
      w = k[0] ? {4'h0, f11, 2'b00, f8, 8'h00} : {6'h00, pos};
      host_u.send(a, k[0] ? 16'h9015 : 16'h9014, 8'h00);
      expect_resp(a, w);
      host_u.send(a + 8'h01, 16'h9014, 8'h00);
      expect_drop();
      host_u.send(a, 16'h9015, 8'h01 << r[19:17]);
      expect_drop();
      host_u.send(a, 16'h9013, 8'h00);
      expect_drop();
    end
    results();
  end
endmodule
`default_nettype wire
